// *** logic/sync_clock_input_select.sv ***
// sync edge select, pixel clock generator with hold, clamp timing and clock select
// Contract
// - act only on selected leading sync edge
// - line sync times lines and references generator
// - hold freezes generator frequency and phase
// - hold sense follows select, reset one
// - hold accepted at any moment
// - clamp gate used only when enabled
// - otherwise clamp timed from sync trailing edge
// - clamp gate sense follows polarity select
// - external clock replaces generated clock
// - phase adjustment works with external clock
// - invert input flips sampling clock
// - slicer output follows input while powered down
//
// Added by the designer: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
module sync_clock_input_select
  import sync_clock_pkg::*;
#(
  parameter logic [ACC_W-1:0] INC_STEP = INCREMENT_STEP
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic line_sync_in,
  input wire logic generator_hold_in,
  input wire logic clamp_gate_in,
  input wire logic green_sync_slicer_input,
  input wire logic external_clock_input,
  input wire logic sample_clock_invert,
  output logic sample_clk,
  output logic clamp_out,
  output logic line_ref_pulse,
  output logic green_sync_slicer_output
);

  localparam int PHASE_N = 1 << PHASE_W;

  // polarity normalisation: result is active high
  function automatic logic norm(input logic level, input logic pol);
    norm = ~(level ^ pol);
  endfunction

  // bus address phase capture
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  wire logic addr_take = hsel & htrans[1] & hready;

  // register file
  logic [CTRL_W-1:0] ctrl_q;
  logic [PIX_W-1:0] target_q;
  logic [CLAMP_W-1:0] clamp_delay_q;
  logic [CLAMP_W-1:0] clamp_dur_q;
  logic [PHASE_W-1:0] phase_q;

  wire logic sync_pol = ctrl_q[CTRL_SYNC_POL_BIT];
  wire logic hold_pol = ctrl_q[CTRL_HOLD_POL_BIT];
  wire logic ext_clamp_en = ctrl_q[CTRL_EXT_CLAMP_BIT];
  wire logic clamp_pol = ctrl_q[CTRL_CLAMP_POL_BIT];
  wire logic ext_clk_sel = ctrl_q[CTRL_EXT_CLK_BIT];
  wire logic power_down = ctrl_q[CTRL_POWER_DOWN_BIT];

  // sync edge detection on the normalised line sync
  logic sync_prev_q;
  wire logic sync_norm = norm(line_sync_in, sync_pol);
  wire logic lead_edge = sync_norm & ~sync_prev_q;
  wire logic trail_edge = ~sync_norm & sync_prev_q;

  // hold is combinational into the tracking logic: no alignment needed
  wire logic hold_active = norm(generator_hold_in, hold_pol);

  // pixel clock generator
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] inc_q;
  logic [PIX_W-1:0] pix_cnt_q;
  logic [LINE_W-1:0] line_cnt_q;
  logic [LINE_W-1:0] period_q;
  logic lock_q;
  logic gen_prev_q;
  wire logic gen_clk = acc_q[ACC_W-1];
  wire logic gen_rise = gen_clk & ~gen_prev_q;
  wire logic track = lead_edge & ~hold_active & ~power_down;
  wire logic too_few = pix_cnt_q < target_q;
  wire logic too_many = pix_cnt_q > target_q;
  wire logic [PIX_W-1:0] target_lo = target_q - PIX_W'(1);
  wire logic [PIX_W-1:0] target_hi = target_q + PIX_W'(1);
  wire logic near_target = (pix_cnt_q >= target_lo) && (pix_cnt_q <= target_hi);
  wire logic [ACC_W-1:0] inc_up = inc_q + INC_STEP;
  wire logic [ACC_W-1:0] inc_dn = inc_q - INC_STEP;
  // saturate so a lost sync cannot wrap the frequency around
  wire logic inc_up_ok = inc_up > inc_q;
  wire logic inc_dn_ok = (inc_dn < inc_q) && (inc_dn != '0);

  logic [ACC_W-1:0] inc_d;
  always_comb begin
    inc_d = inc_q;
    if (track && too_few && inc_up_ok) begin
      inc_d = inc_up;
    end else if (track && too_many && inc_dn_ok) begin
      inc_d = inc_dn;
    end
  end

  // phase re-aligned on each tracked edge, cleared in power down; advances by inc_q otherwise
  logic [ACC_W-1:0] acc_d;
  always_comb begin
    if (power_down) begin
      acc_d = '0;
    end else if (track) begin
      acc_d = '0;
    end else begin
      acc_d = acc_q + inc_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_q <= '0;
      inc_q <= INCREMENT_RESET;
      gen_prev_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      inc_q <= inc_d;
      gen_prev_q <= gen_clk;
    end
  end

  // per-line pixel and cycle counts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pix_cnt_q <= '0;
      line_cnt_q <= '0;
      period_q <= '0;
      lock_q <= 1'b0;
    end else if (lead_edge) begin
      pix_cnt_q <= '0;
      line_cnt_q <= LINE_W'(1);
      period_q <= line_cnt_q;
      lock_q <= hold_active ? lock_q : near_target;
    end else begin
      if (gen_rise && (pix_cnt_q != '1)) begin
        pix_cnt_q <= pix_cnt_q + PIX_W'(1);
      end
      if (line_cnt_q != '1) begin
        line_cnt_q <= line_cnt_q + LINE_W'(1);
      end
    end
  end

  // clock source select, then phase delay line, then inversion
  wire logic src_clk = ext_clk_sel ? external_clock_input : gen_clk;
  logic [PHASE_N-1:0] delay_q;
  wire logic phased_clk = delay_q[phase_q];
  wire logic sample_d = phased_clk ^ sample_clock_invert;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      delay_q <= '0;
      sample_clk <= 1'b0;
    end else begin
      delay_q <= {delay_q[PHASE_N-2:0], src_clk};
      sample_clk <= sample_d;
    end
  end

  // internal clamp timing from trailing edge
  clamp_state_t cl_state_q;
  clamp_state_t cl_state_d;
  logic [CLAMP_W-1:0] cl_cnt_q;
  logic [CLAMP_W-1:0] cl_cnt_d;
  wire logic cl_cnt_last = cl_cnt_q <= CLAMP_W'(1);

  always_comb begin
    cl_state_d = cl_state_q;
    cl_cnt_d = cl_cnt_q;
    if (power_down) begin
      cl_state_d = CLAMP_IDLE;
      cl_cnt_d = '0;
    end else if (trail_edge) begin
      cl_state_d = CLAMP_WAIT;
      cl_cnt_d = clamp_delay_q;
    end else begin
      unique case (cl_state_q)
        CLAMP_IDLE: begin
          cl_cnt_d = '0;
        end
        CLAMP_WAIT: begin
          if (cl_cnt_last) begin
            cl_state_d = (clamp_dur_q == '0) ? CLAMP_IDLE : CLAMP_ON;
            cl_cnt_d = clamp_dur_q;
          end else begin
            cl_cnt_d = cl_cnt_q - CLAMP_W'(1);
          end
        end
        CLAMP_ON: begin
          if (cl_cnt_last) begin
            cl_state_d = CLAMP_IDLE;
            cl_cnt_d = '0;
          end else begin
            cl_cnt_d = cl_cnt_q - CLAMP_W'(1);
          end
        end
        default: begin
          cl_state_d = CLAMP_IDLE;
          cl_cnt_d = '0;
        end
      endcase
    end
  end

  // gate ignored entirely while external clamp is disabled
  wire logic ext_clamp = norm(clamp_gate_in, clamp_pol);
  wire logic clamp_d = ext_clamp_en ? ext_clamp : (cl_state_q == CLAMP_ON);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cl_state_q <= CLAMP_IDLE;
      cl_cnt_q <= '0;
      clamp_out <= 1'b0;
      sync_prev_q <= 1'b0;
      line_ref_pulse <= 1'b0;
    end else begin
      cl_state_q <= cl_state_d;
      cl_cnt_q <= cl_cnt_d;
      clamp_out <= clamp_d & ~power_down;
      sync_prev_q <= sync_norm;
      line_ref_pulse <= lead_edge;
    end
  end

  // slicer output runs regardless of power down
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      green_sync_slicer_output <= 1'b0;
    end else begin
      green_sync_slicer_output <= green_sync_slicer_input;
    end
  end

  // data phase write
  wire logic wr_ctrl = wr_pend_q && (wr_addr_q == CTRL_OFFSET);
  wire logic wr_target = wr_pend_q && (wr_addr_q == LINE_TARGET_OFFSET);
  wire logic wr_clamp = wr_pend_q && (wr_addr_q == CLAMP_TIME_OFFSET);
  wire logic wr_phase = wr_pend_q && (wr_addr_q == PHASE_OFFSET);

  // register read decode
  wire logic [7:0] rd_addr = haddr[7:0];
  wire logic [31:0] ctrl_rd = {{(32-CTRL_W){1'b0}}, ctrl_q};
  wire logic [31:0] target_rd = {{(32-PIX_W){1'b0}}, target_q};
  wire logic [31:0] clamp_rd = {16'h0000, clamp_dur_q, clamp_delay_q};
  wire logic [31:0] phase_rd = {{(32-PHASE_W){1'b0}}, phase_q};
  // a read taken in a write's data phase must see the word being written,
  // since the register itself only changes at the same edge
  wire logic [31:0] ctrl_fwd = wr_ctrl ? {{(32-CTRL_W){1'b0}}, hwdata[CTRL_W-1:0]} : ctrl_rd;
  wire logic [31:0] target_fwd = wr_target ? {{(32-PIX_W){1'b0}}, hwdata[PIX_W-1:0]} : target_rd;
  wire logic [31:0] clamp_wr = {16'h0000, hwdata[CLAMP_DUR_LSB +: CLAMP_W], hwdata[CLAMP_DELAY_LSB +: CLAMP_W]};
  wire logic [31:0] clamp_fwd = wr_clamp ? clamp_wr : clamp_rd;
  wire logic [31:0] phase_fwd = wr_phase ? {{(32-PHASE_W){1'b0}}, hwdata[PHASE_W-1:0]} : phase_rd;
  wire logic [31:0] status_rd = {period_q, 12'h000, sync_norm, lock_q, clamp_out, hold_active};
  wire logic in_page = haddr[31:8] == 24'h000000;
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (in_page) begin
      unique case (rd_addr)
        CTRL_OFFSET: rd_data = ctrl_fwd;
        LINE_TARGET_OFFSET: rd_data = target_fwd;
        CLAMP_TIME_OFFSET: rd_data = clamp_fwd;
        PHASE_OFFSET: rd_data = phase_fwd;
        STATUS_OFFSET: rd_data = status_rd;
        INCREMENT_OFFSET: rd_data = inc_q;
        default: rd_data = 32'h0000_0000;
      endcase
    end
  end

  // bus slave: zero wait states, always OKAY
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= addr_take & hwrite & in_page;
      wr_addr_q <= rd_addr;
      if (addr_take && !hwrite) begin
        hrdata <= rd_data;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      target_q <= LINE_TARGET_RESET;
      clamp_delay_q <= CLAMP_DELAY_RESET;
      clamp_dur_q <= CLAMP_DUR_RESET;
      phase_q <= PHASE_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata[CTRL_W-1:0];
      end
      if (wr_target) begin
        target_q <= hwdata[PIX_W-1:0];
      end
      if (wr_clamp) begin
        clamp_delay_q <= hwdata[CLAMP_DELAY_LSB +: CLAMP_W];
        clamp_dur_q <= hwdata[CLAMP_DUR_LSB +: CLAMP_W];
      end
      if (wr_phase) begin
        phase_q <= hwdata[PHASE_W-1:0];
      end
    end
  end

endmodule // sync_clock_input_select

// *** logic/sync_clock_pkg.sv ***
// constants for the sync, clamp and pixel clock control block
package sync_clock_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] LINE_TARGET_OFFSET = 8'h04;
  localparam logic [7:0] CLAMP_TIME_OFFSET = 8'h08;
  localparam logic [7:0] PHASE_OFFSET = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;
  localparam logic [7:0] INCREMENT_OFFSET = 8'h14;

  // control register fields
  localparam int CTRL_SYNC_POL_BIT = 0;
  localparam int CTRL_HOLD_POL_BIT = 1;
  localparam int CTRL_EXT_CLAMP_BIT = 2;
  localparam int CTRL_CLAMP_POL_BIT = 3;
  localparam int CTRL_EXT_CLK_BIT = 4;
  localparam int CTRL_POWER_DOWN_BIT = 5;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h0A;

  // line target: pixels per line
  localparam int PIX_W = 12;
  localparam logic [PIX_W-1:0] LINE_TARGET_RESET = 12'h400;

  // clamp timing: delay in [7:0], duration in [15:8]
  localparam int CLAMP_W = 8;
  localparam int CLAMP_DELAY_LSB = 0;
  localparam int CLAMP_DUR_LSB = 8;
  localparam logic [CLAMP_W-1:0] CLAMP_DELAY_RESET = 8'h08;
  localparam logic [CLAMP_W-1:0] CLAMP_DUR_RESET = 8'h14;

  // sampling phase steps
  localparam int PHASE_W = 5;
  localparam logic [PHASE_W-1:0] PHASE_RESET = 5'h00;

  // status fields
  localparam int STAT_HOLD_BIT = 0;
  localparam int STAT_CLAMP_BIT = 1;
  localparam int STAT_LOCK_BIT = 2;
  localparam int STAT_SYNC_BIT = 3;
  localparam int STAT_PERIOD_LSB = 16;
  localparam int LINE_W = 16;

  // pixel clock generator accumulator
  localparam int ACC_W = 32;
  localparam logic [ACC_W-1:0] INCREMENT_RESET = 32'h2000_0000;
  localparam logic [ACC_W-1:0] INCREMENT_STEP = 32'h0000_1000;

  typedef enum logic [1:0] {CLAMP_IDLE, CLAMP_WAIT, CLAMP_ON} clamp_state_t;

endpackage

// *** tb/video_source.sv ***
// video source model: line sync and back porch clamp gate
`timescale 1ns/1ps
module video_source #(
  parameter int LINE_LEN = 100
) (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic spol,
  output logic line_sync_in,
  output logic clamp_gate_in
);
  logic [11:0] pos_q = 12'h000;
  wire logic act = run && pos_q >= 12'h001 && pos_q <= 12'h010;
  always_ff @(posedge sys_clk) begin
    pos_q <= (!run || pos_q == 12'(LINE_LEN - 1)) ? 12'h000 : pos_q + 12'h001;
  end
  // idle is the inactive level, never floating
  assign line_sync_in = ~(act ^ spol);
  assign clamp_gate_in = run && pos_q >= 12'h014 && pos_q < 12'h01E;
endmodule // video_source

// *** tb/sync_clock_props.sv ***
// checker for the sync, clamp and sample clock ports
`timescale 1ns/1ps
module sync_clock_props
  import sync_clock_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic line_sync_in,
  input wire logic clamp_gate_in,
  input wire logic green_sync_slicer_input,
  input wire logic external_clock_input,
  input wire logic sample_clock_invert,
  input wire logic sample_clk,
  input wire logic clamp_out,
  input wire logic line_ref_pulse,
  input wire logic green_sync_slicer_output
);
  logic wr_q;
  logic [7:0] adr_q;
  logic [CTRL_W-1:0] ctl_q;
  logic [PHASE_W-1:0] ph_q;
  logic [3:0] age_q;
  // shadow of control and phase, snooped at the data phase like the slave
  always_ff @(posedge sys_clk) begin
    wr_q <= hsel && htrans[1] && hwrite && hready && !rst;
    adr_q <= haddr[7:0];
    age_q <= (rst || wr_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
    if (rst) begin
      ctl_q <= CTRL_RESET;
      ph_q <= PHASE_RESET;
    end else if (wr_q && adr_q == CTRL_OFFSET) begin
      ctl_q <= hwdata[CTRL_W-1:0];
    end else if (wr_q && adr_q == PHASE_OFFSET) begin
      ph_q <= hwdata[PHASE_W-1:0];
    end
  end
  wire logic sn = ~(line_sync_in ^ ctl_q[CTRL_SYNC_POL_BIT]);
  wire logic gn = ~(clamp_gate_in ^ ctl_q[CTRL_CLAMP_POL_BIT]);
  // settled config only: a write mid-window would blur the latencies
  wire logic calm = age_q == 4'hF && !ctl_q[CTRL_POWER_DOWN_BIT];
  wire logic xclk = calm && ctl_q[CTRL_EXT_CLK_BIT];
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_ref_leading: assert property (line_ref_pulse |-> $past(sn) && !$past(sn, 2))
    else $error("line ref pulse without leading edge");
  a_ref_follows: assert property ($rose(sn) && !ctl_q[CTRL_POWER_DOWN_BIT] |=> line_ref_pulse ##1 !line_ref_pulse)
    else $error("leading edge gave no single ref pulse");
  a_clamp_gate: assert property (ctl_q[CTRL_EXT_CLAMP_BIT] && calm |-> clamp_out == $past(gn))
    else $error("clamp does not follow gate");
  a_clamp_timed: assert property ($fell(sn) && !ctl_q[CTRL_EXT_CLAMP_BIT] && calm |-> ##[8:12] clamp_out)
    else $error("internal clamp late");
  a_clk_direct: assert property (xclk && ph_q == 5'h00 |->
    sample_clk == ($past(external_clock_input, 2) ^ $past(sample_clock_invert)))
    else $error("sample clock not external clock");
  a_clk_phase: assert property (xclk && ph_q == 5'h03 |->
    sample_clk == ($past(external_clock_input, 5) ^ $past(sample_clock_invert)))
    else $error("phase delay lost on external clock");
  a_slicer_copy: assert property (green_sync_slicer_output == $past(green_sync_slicer_input))
    else $error("slicer output wrong");
  a_clamp_off: assert property (ctl_q[CTRL_POWER_DOWN_BIT] && age_q == 4'hF |-> !clamp_out)
    else $error("clamp during power down");
  cover property (line_ref_pulse);
  cover property (ctl_q[CTRL_EXT_CLAMP_BIT] && clamp_out);
  cover property (xclk && sample_clk);
endmodule // sync_clock_props
bind sync_clock_input_select sync_clock_props i_sync_clock_props (.sys_clk, .rst, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .line_sync_in, .clamp_gate_in, .green_sync_slicer_input, .external_clock_input,
  .sample_clock_invert, .sample_clk, .clamp_out, .line_ref_pulse, .green_sync_slicer_output);

// *** tb/sync_clock_input_select_bench.sv ***
// self-checking bench for the sync, clamp and sample clock block
`timescale 1ns/1ps
module sync_clock_input_select_bench;
  import sync_clock_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic generator_hold_in = 1'b0;
  logic green_sync_slicer_input = 1'b0;
  logic external_clock_input = 1'b0;
  logic sample_clock_invert = 1'b0;
  logic run = 1'b0;
  logic spol = 1'b0;
  wire logic hready, hreadyout, hresp, line_sync_in, clamp_gate_in;
  wire logic sample_clk, clamp_out, line_ref_pulse, green_sync_slicer_output;
  wire logic [31:0] hrdata;
  logic [31:0] d0, d1;
  int bad_count = 0;
  int check_count = 0;
  assign hready = hreadyout;
  video_source i_video_source (.sys_clk, .run, .spol, .line_sync_in, .clamp_gate_in);
  sync_clock_input_select i_sync_clock_input_select (.sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .line_sync_in, .generator_hold_in, .clamp_gate_in,
    .green_sync_slicer_input, .external_clock_input, .sample_clock_invert, .sample_clk, .clamp_out,
    .line_ref_pulse, .green_sync_slicer_output);
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    q = hrdata;
    chk("hresp", '0, {31'h0, hresp});
  endtask
  // after one line length to settle, count clamp high cycles over the next line length
  task automatic clamp_cnt(input logic [31:0] e);
    int n;
    n = 0;
    repeat (100) @(posedge sys_clk);
    repeat (100) begin
      @(posedge sys_clk);
      n += int'(clamp_out === 1'b1);
    end
    chk("clamp_cycles", e, n);
  endtask
  task automatic t_clamp;
    bus(1'b0, CTRL_OFFSET, '0, d0);
    chk("ctrl_reset", {26'h0, CTRL_RESET}, d0);
    bus(1'b0, 8'h18, '0, d0);
    chk("unmapped", '0, d0);
    run <= 1'b1;
    clamp_cnt({24'h0, CLAMP_DUR_RESET});
    bus(1'b1, CTRL_OFFSET, 32'h0000_000E, d0);
    clamp_cnt(32'h0000_000A);
    bus(1'b1, CTRL_OFFSET, 32'h0000_0006, d0);
    clamp_cnt(32'h0000_005A);
    spol <= 1'b1;
    bus(1'b1, CTRL_OFFSET, 32'h0000_000B, d0);
    clamp_cnt({24'h0, CLAMP_DUR_RESET});
  endtask
  task automatic t_hold;
    generator_hold_in <= 1'b1;
    repeat (37) @(posedge sys_clk);
    bus(1'b0, STATUS_OFFSET, '0, d0);
    chk("hold_high", 32'h1, {31'h0, d0[STAT_HOLD_BIT]});
    bus(1'b0, INCREMENT_OFFSET, '0, d0);
    repeat (300) @(posedge sys_clk);
    bus(1'b0, INCREMENT_OFFSET, '0, d1);
    chk("inc_frozen", d0, d1);
    generator_hold_in <= 1'b0;
    repeat (300) @(posedge sys_clk);
    bus(1'b0, INCREMENT_OFFSET, '0, d1);
    chk("inc_tracks", 32'h1, {31'h0, d1 !== d0});
    bus(1'b1, CTRL_OFFSET, 32'h0000_0009, d1);
    bus(1'b0, STATUS_OFFSET, '0, d0);
    chk("hold_low", 32'h1, {31'h0, d0[STAT_HOLD_BIT]});
    bus(1'b1, CTRL_OFFSET, 32'h0000_000B, d1);
  endtask
  task automatic t_clk;
    bus(1'b1, CTRL_OFFSET, 32'h0000_001B, d0);
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, PHASE_OFFSET, 32'(p * 3), d0);
      for (int v = 0; v < 4; v++) begin
        sample_clock_invert <= v[1];
        repeat (20) begin
          @(posedge sys_clk);
          external_clock_input <= ~external_clock_input;
        end
        @(posedge sys_clk);
        external_clock_input <= v[0];
        repeat (12) @(posedge sys_clk);
        chk("sample_clk", {31'h0, v[0] ^ v[1]}, {31'h0, sample_clk});
      end
    end
  endtask
  task automatic t_slicer;
    bus(1'b1, CTRL_OFFSET, 32'h0000_002B, d0);
    for (int v = 0; v < 2; v++) begin
      green_sync_slicer_input <= ~v[0];
      repeat (30) @(posedge sys_clk);
      chk("slicer", {31'h0, ~v[0]}, {31'h0, green_sync_slicer_output});
    end
  endtask
  task automatic results;
    if (bad_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_clamp();
    t_hold();
    t_clk();
    t_slicer();
    results();
  end
  // whole run is under two thousand cycles
  initial begin
    #60000;
    bad_count++;
    results();
  end
endmodule // sync_clock_input_select_bench
